//--- hdl/utxb_core.sv
// serial port transmit and receive datapath with buffers, flags and requests
`timescale 1ns/1ps
`default_nettype none
module utxb_core
    import utxb_pkg::*;
#(
    parameter int DEPTH = utxb_pkg::RX_DEPTH
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // bit timing
    input  wire logic        baud_tick,
    input  wire logic        sync_mode,
    input  wire logic        sync_clock_pin,
    // interrupt interface
    input  wire logic        global_irq_en,
    input  wire logic        tx_done_irq_ack,
    output utxb_pkg::utxb_irq_t irq_req,
    // serial pins
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    output logic             rx_pin_owned
);
    import utxb_pkg::*;

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} utxb_tx_st_t;
    typedef enum {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} utxb_rx_st_t;

    function automatic logic [3:0] utxb_bits(input logic [2:0] sz);
        utxb_bits = (sz == SIZE_NINE) ? 4'h9 : (sz[2] ? 4'h8 : 4'(5 + sz[1:0]));
    endfunction

    function automatic logic utxb_par(input logic [8:0] d, input logic [3:0] n,
                                      input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++)
            if (4'(i) < n)
                p = p ^ d[i];
        utxb_par = p;
    endfunction

    // pin synchronisers
    logic [1:0] rxd_s_r;
    logic [1:0] sck_s_r;
    logic       sck_d_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            sck_d_r <= 1'b0;
        end
        else
        begin
            rxd_s_r <= {rxd_s_r[0], serial_in_pin};
            sck_s_r <= {sck_s_r[0], sync_clock_pin};
            sck_d_r <= sck_s_r[1];
        end
    end

    // tick: baud generator pulse or rising sync clock edge
    logic tick;
    assign tick = sync_mode ? (sck_s_r[1] & ~sck_d_r) : baud_tick;

    // control registers
    logic [7:0] ctrl_b_r;
    logic [7:0] ctrl_c_r;
    logic [2:0] char_size_field;
    logic [3:0] nbits;
    logic       parity_enable_bit;
    logic       parity_odd_select;
    logic       rx_enable_bit;
    logic       wr_data;
    logic       rd_data;
    assign char_size_field   = {ctrl_b_r[BIT_SZ2], ctrl_c_r[BIT_SZ1], ctrl_c_r[BIT_SZ0]};
    assign nbits             = utxb_bits(char_size_field);
    assign parity_enable_bit = ctrl_c_r[BIT_PEN];
    assign parity_odd_select = ctrl_c_r[BIT_PODD];
    assign rx_enable_bit     = ctrl_b_r[BIT_RXEN];
    assign wr_data           = reg_wr && reg_addr == ADDR_DATA;
    assign rd_data           = reg_rd && reg_addr == ADDR_DATA;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_b_r <= RST_CTRL_B;
            ctrl_c_r <= RST_CTRL_C;
        end
        else if (reg_wr && reg_addr == ADDR_CTRL_B)
            ctrl_b_r <= reg_wdata;
        else if (reg_wr && reg_addr == ADDR_CTRL_C)
            ctrl_c_r <= reg_wdata;
    end

    // transmit buffer
    logic       txbuf_full_r;
    logic [8:0] txbuf_r;
    logic       tx_load;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            txbuf_full_r <= 1'b0;
            txbuf_r      <= 9'h000;
        end
        else if (wr_data)
        begin
            txbuf_full_r <= 1'b1;
            txbuf_r      <= {ctrl_b_r[BIT_TX8], reg_wdata};
        end
        else if (tx_load)
            txbuf_full_r <= 1'b0;
    end

    // transmit shifter
    utxb_tx_st_t tx_st_r;
    logic [8:0]  tx_sh_r;
    logic [3:0]  tx_cnt_r;
    logic        tx_par_r;
    logic        tx_line_r;
    logic        tx_busy;
    logic        tx_active_r;
    logic        tx_end;
    logic        tx_tail_r;
    assign tx_busy = tx_st_r != TX_IDLE;
    assign tx_end  = tx_st_r == TX_STOP && tick
                     && (tx_cnt_r == 4'h0 || !ctrl_c_r[BIT_SBS]);
    assign tx_load = txbuf_full_r && tx_active_r && (!tx_busy || tx_end);

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_st_r   <= TX_IDLE;
            tx_sh_r   <= 9'h000;
            tx_cnt_r  <= 4'h0;
            tx_par_r  <= 1'b0;
            tx_line_r <= 1'b1;
        end
        else if (tx_load)
        begin
            tx_st_r  <= TX_START;
            tx_sh_r  <= txbuf_r;
            tx_par_r <= utxb_par(txbuf_r, nbits, parity_odd_select);
            tx_cnt_r <= 4'h0;
            // a load on the last stop tick must still put that stop bit on the line
            if (tick)
                tx_line_r <= 1'b1;
        end
        else if (tick)
        begin
            case (tx_st_r)
                TX_IDLE:
                    tx_line_r <= 1'b1;
                TX_START:
                begin
                    tx_line_r <= 1'b0;
                    tx_st_r   <= TX_DATA;
                end
                TX_DATA:
                begin
                    tx_line_r <= tx_sh_r[0];
                    tx_sh_r   <= {1'b0, tx_sh_r[8:1]};
                    tx_cnt_r  <= tx_cnt_r + 4'h1;
                    if (tx_cnt_r == nbits - 4'h1)
                        tx_st_r <= parity_enable_bit ? TX_PAR : TX_STOP;
                end
                TX_PAR:
                begin
                    tx_line_r <= tx_par_r;
                    tx_st_r   <= TX_STOP;
                    tx_cnt_r  <= 4'h1;
                end
                TX_STOP:
                begin
                    tx_line_r <= 1'b1;
                    if (tx_cnt_r == 4'h0 || !ctrl_c_r[BIT_SBS])
                        tx_st_r <= TX_IDLE;
                    tx_cnt_r  <= 4'h0;
                end
                default:
                    tx_st_r <= TX_IDLE;
            endcase
        end
    end

    // the last stop bit stays on the line until the next tick; done and release wait for it
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            tx_tail_r <= 1'b0;
        else if (tx_end)
            tx_tail_r <= 1'b1;
        else if (tick)
            tx_tail_r <= 1'b0;
    end

    // deferred transmitter disable and pin ownership
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            tx_active_r <= 1'b0;
        else if (ctrl_b_r[BIT_TX_ENABLE_BIT])
            tx_active_r <= 1'b1;
        else if (!tx_busy && !txbuf_full_r && !tx_tail_r)
            tx_active_r <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_out_pin <= 1'b1;
            serial_out_oe  <= 1'b0;
            rx_pin_owned   <= 1'b0;
        end
        else
        begin
            serial_out_pin <= tx_line_r;
            serial_out_oe  <= tx_active_r;
            rx_pin_owned   <= rx_enable_bit;
        end
    end

    // transmit done flag: set wins over clear
    logic tx_done_flag;
    logic tx_done_set;
    assign tx_done_set = tx_tail_r && tick && !tx_busy && !txbuf_full_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            tx_done_flag <= 1'b0;
        else if (tx_done_set)
            tx_done_flag <= 1'b1;
        else if (tx_done_irq_ack
                 || (reg_wr && reg_addr == ADDR_STAT_A && reg_wdata[BIT_TXC]))
            tx_done_flag <= 1'b0;
    end

    // receiver
    utxb_rx_st_t rx_st_r;
    logic [8:0]  rx_sh_r;
    logic [3:0]  rx_cnt_r;
    logic        rx_perr_r;
    logic        rx_frame_done;
    logic        rx_stop_bit;
    assign rx_frame_done = rx_st_r == RX_STOP && tick;
    assign rx_stop_bit   = rxd_s_r[1];

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_st_r   <= RX_IDLE;
            rx_sh_r   <= 9'h000;
            rx_cnt_r  <= 4'h0;
            rx_perr_r <= 1'b0;
        end
        else if (!rx_enable_bit)
            rx_st_r <= RX_IDLE;
        else if (tick)
        begin
            case (rx_st_r)
                RX_IDLE:
                    if (!rxd_s_r[1])
                    begin
                        rx_st_r  <= RX_DATA;
                        rx_cnt_r <= 4'h0;
                        rx_sh_r  <= 9'h000;
                    end
                RX_DATA:
                begin
                    rx_sh_r[rx_cnt_r] <= rxd_s_r[1];
                    rx_cnt_r          <= rx_cnt_r + 4'h1;
                    if (rx_cnt_r == nbits - 4'h1)
                        rx_st_r <= parity_enable_bit ? RX_PAR : RX_STOP;
                end
                RX_PAR:
                begin
                    rx_perr_r <= utxb_par(rx_sh_r, nbits, parity_odd_select) != rxd_s_r[1];
                    rx_st_r   <= RX_STOP;
                end
                RX_STOP:
                    rx_st_r <= RX_IDLE;
                default:
                    rx_st_r <= RX_IDLE;
            endcase
        end
    end

    // receive buffer fifo with per-entry status
    utxb_rx_entry_t   rx_mem [DEPTH];
    logic [$clog2(DEPTH):0] rx_cnt_q_r;
    logic [$clog2(DEPTH)-1:0] rx_wp_r;
    logic [$clog2(DEPTH)-1:0] rx_rp_r;
    logic             rx_dor_r;
    logic             rx_push;
    logic             rx_pop;
    logic             rx_ready_flag;
    utxb_rx_entry_t   rx_head;
    assign rx_ready_flag = rx_cnt_q_r != '0;
    assign rx_pop        = rd_data && rx_ready_flag;
    assign rx_push       = rx_frame_done && (rx_cnt_q_r != ($clog2(DEPTH)+1)'(DEPTH) || rx_pop);
    assign rx_head       = rx_mem[rx_rp_r];

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rx_dor_r <= 1'b0;
        else if (rx_push)
            rx_dor_r <= 1'b0;
        else if (rx_frame_done)
            rx_dor_r <= 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rx_push)
            rx_mem[rx_wp_r] <= '{data: rx_sh_r, fe: !rx_stop_bit, dor: rx_dor_r,
                                  upe: parity_enable_bit & rx_perr_r};
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_cnt_q_r <= '0;
            rx_wp_r    <= '0;
            rx_rp_r    <= '0;
        end
        else if (!rx_enable_bit)
        begin
            rx_cnt_q_r <= '0;
            rx_wp_r    <= '0;
            rx_rp_r    <= '0;
        end
        else
        begin
            if (rx_push)
                rx_wp_r <= (rx_wp_r == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rx_wp_r + 1'b1;
            if (rx_pop)
                rx_rp_r <= (rx_rp_r == ($clog2(DEPTH))'(DEPTH - 1)) ? '0 : rx_rp_r + 1'b1;
            rx_cnt_q_r <= rx_cnt_q_r + (rx_push ? 1'b1 : 1'b0) - (rx_pop ? 1'b1 : 1'b0);
        end
    end

    // read data, one cycle after the strobe
    logic [7:0] rd_mask;
    assign rd_mask = 8'hFF >> (4'h8 - (nbits > 4'h8 ? 4'h8 : nbits));
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_DATA:
                    reg_rdata <= rx_ready_flag ? (rx_head.data[7:0] & rd_mask) : 8'h00;
                ADDR_STAT_A:
                    reg_rdata <= {rx_ready_flag, tx_done_flag, !txbuf_full_r,
                                  rx_ready_flag & rx_head.fe, rx_ready_flag & rx_head.dor,
                                  rx_ready_flag & rx_head.upe, 2'h0};
                ADDR_CTRL_B:
                    reg_rdata <= {ctrl_b_r[7:2],
                                  rx_ready_flag & rx_head.data[8] & (char_size_field == SIZE_NINE),
                                  ctrl_b_r[BIT_TX8]};
                ADDR_CTRL_C:
                    reg_rdata <= ctrl_c_r;
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    // interrupt requests
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_req <= '0;
        else
        begin
            irq_req.tx_empty <= global_irq_en & ctrl_b_r[BIT_DEIE] & !txbuf_full_r;
            irq_req.tx_done  <= global_irq_en & ctrl_b_r[BIT_TXIE] & tx_done_flag;
            irq_req.rx_done  <= global_irq_en & ctrl_b_r[BIT_RXIE] & rx_ready_flag;
        end
    end

    // checks
    property p_wr_clears_empty;
        @(posedge ref_clk) disable iff (!rst_b)
        wr_data |=> txbuf_full_r;
    endproperty
    a_wr_clears_empty: assert property (p_wr_clears_empty) else $error("data write did not fill buffer");

    property p_empty_irq;
        @(posedge ref_clk) disable iff (!rst_b)
        (global_irq_en && ctrl_b_r[BIT_DEIE] && !txbuf_full_r) |=> irq_req.tx_empty;
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("empty request missing");

    property p_done_set;
        @(posedge ref_clk) disable iff (!rst_b)
        tx_done_set |=> tx_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_done_ack;
        @(posedge ref_clk) disable iff (!rst_b)
        (tx_done_irq_ack && !tx_done_set) |=> !tx_done_flag;
    endproperty
    a_done_ack: assert property (p_done_ack) else $error("done flag not cleared");

    property p_disable_deferred;
        @(posedge ref_clk) disable iff (!rst_b)
        (tx_busy || txbuf_full_r) && tx_active_r |=> tx_active_r;
    endproperty
    a_disable_deferred: assert property (p_disable_deferred) else $error("early disable");

    sequence s_stop_now;
        rx_frame_done && rx_enable_bit;
    endsequence
    property p_frame_stored;
        @(posedge ref_clk) disable iff (!rst_b)
        s_stop_now ##0 (rx_cnt_q_r == '0) |=> rx_ready_flag;
    endproperty
    a_frame_stored: assert property (p_frame_stored) else $error("frame not buffered");

    property p_flush;
        @(posedge ref_clk) disable iff (!rst_b)
        !rx_enable_bit |=> !rx_ready_flag;
    endproperty
    a_flush: assert property (p_flush) else $error("buffer not flushed");

    property p_rx_irq;
        @(posedge ref_clk) disable iff (!rst_b)
        (global_irq_en && ctrl_b_r[BIT_RXIE] && rx_ready_flag) |=> irq_req.rx_done;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive request missing");
endmodule
`default_nettype wire

//--- hdl/utxb_pkg.sv
// shared constants and types for the serial transmit/receive buffer block
package utxb_pkg;
    // register addresses (word index on the plain port)
    localparam logic [1:0] ADDR_DATA   = 2'h0;
    localparam logic [1:0] ADDR_STAT_A = 2'h1;
    localparam logic [1:0] ADDR_CTRL_B = 2'h2;
    localparam logic [1:0] ADDR_CTRL_C = 2'h3;
    // status_control_a bits
    localparam int BIT_RXC  = 7;
    localparam int BIT_TXC  = 6;
    localparam int BIT_UDRE = 5;
    localparam int BIT_FE   = 4;
    localparam int BIT_DOR  = 3;
    localparam int BIT_UPE  = 2;
    // control_b bits
    localparam int BIT_RXIE = 7;
    localparam int BIT_TXIE = 6;
    localparam int BIT_DEIE = 5;
    localparam int BIT_RXEN = 4;
    localparam int BIT_TX_ENABLE_BIT = 3;
    localparam int BIT_SZ2  = 2;
    localparam int BIT_RX8  = 1;
    localparam int BIT_TX8  = 0;
    // control_c bits
    localparam int BIT_PEN  = 5;
    localparam int BIT_PODD = 4;
    localparam int BIT_SBS  = 3;
    localparam int BIT_SZ1  = 2;
    localparam int BIT_SZ0  = 1;
    // reset values, nine-bit size code and receive depth
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_CTRL_C = 8'h06;
    localparam logic [2:0] SIZE_NINE  = 3'h7;
    localparam int         RX_DEPTH   = 2;

    // one receive buffer entry
    typedef struct packed {
        logic [8:0] data;
        logic       fe;
        logic       dor;
        logic       upe;
    } utxb_rx_entry_t;

    // interrupt request lines
    typedef struct packed {
        logic rx_done;
        logic tx_empty;
        logic tx_done;
    } utxb_irq_t;
endpackage

//--- testbench/utxb_core_bench.sv
// register-level bench for the serial transmit/receive buffer block
`timescale 1ns/1ps
`default_nettype none
module utxb_core_bench;
    import utxb_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  reg_addr = '0;
    logic [7:0]  reg_wdata = '0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        baud_tick = 1'b0;
    logic        sync_mode = 1'b0;
    logic        sync_clock_pin = 1'b0;
    logic        global_irq_en = 1'b1;
    logic        tx_done_irq_ack = 1'b0;
    utxb_irq_t   irq_req;
    logic        rx_line;
    logic        serial_out_pin;
    logic        serial_out_oe;
    logic        rx_pin_owned;
    logic        tx_line;
    logic        ptick = 1'b0;
    logic [2:0]  phase = '0;
    int          miscompares = 0;
    int          compares = 0;
    logic [7:0]  rv;
    logic [10:0] e;
    logic [2:0]  code;
    logic [1:0]  pp;
    logic [8:0]  d;
    logic [8:0]  m;
    logic        sv;
    int          nb;
    // size code, {parity on, odd}, character, stop bit level
    logic [14:0] rows [5] = '{{3'h3, 2'h0, 9'h1A5, 1'b1}, {3'h0, 2'h2, 9'h0F3, 1'b0},
                              {3'h1, 2'h0, 9'h0AB, 1'b1}, {3'h2, 2'h3, 9'h0D6, 1'b1},
                              {3'h7, 2'h2, 9'h15A, 1'b1}};

    always #12.5 ref_clk = ~ref_clk;

    // bit time is 8 clocks, from the tick or from the external clock
    always @(posedge ref_clk)
    begin
        phase <= phase + 3'h1;
        sync_clock_pin <= phase[2];
        baud_tick <= !sync_mode && phase == 3'h7;
        ptick <= sync_mode ? phase == 3'h4 : phase == 3'h7;
    end

    // a released output floats up to the idle level
    assign tx_line = serial_out_oe ? serial_out_pin : 1'b1;

    utxb_core utxb_core_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_tick(baud_tick),
        .sync_mode(sync_mode), .sync_clock_pin(sync_clock_pin),
        .global_irq_en(global_irq_en), .tx_done_irq_ack(tx_done_irq_ack),
        .irq_req(irq_req), .serial_in_pin(rx_line), .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe), .rx_pin_owned(rx_pin_owned)
    );

    utxb_remote utxb_remote_i (
        .ref_clk(ref_clk), .tick(ptick), .line_in(tx_line), .line_out(rx_line)
    );

    task automatic chk(input string n, input logic [8:0] x, input logic [8:0] s);
        compares++;
        if (s !== x)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    // status bits 1:0 are outside this block, so they are masked off
    task automatic rc(input logic [1:0] a, input string n, input logic [7:0] x,
                      input logic [7:0] mk = 8'hFF);
        rd(a);
        chk(n, {1'b0, x & mk}, {1'b0, rv & mk});
    endtask

    task automatic wait_q(input int n);
        for (int i = 0; i < 2000 && utxb_remote_i.rxq.size() < n; i++)
            @(posedge ref_clk);
        chk("frames", 9'(n), 9'(utxb_remote_i.rxq.size()));
    endtask

    task automatic txc(input logic [8:0] x, input logic p);
        e = utxb_remote_i.rxq.pop_front();
        chk("tx data", x, e[8:0]);
        chk("tx parity", 9'(p), 9'(e[9]));
        chk("tx stop", 9'h1, 9'(e[10]));
    endtask

    task automatic summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        summarize();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        rc(ADDR_CTRL_B, "ctrl_b", RST_CTRL_B);
        rc(ADDR_CTRL_C, "ctrl_c", RST_CTRL_C);
        rc(ADDR_STAT_A, "status", 8'h20, 8'hFC);
        chk("pin", 9'h1, 9'(serial_out_pin));
        wr(ADDR_CTRL_B, 8'h28);
        rc(ADDR_STAT_A, "status", 8'h20, 8'hFC);
        chk("irq empty", 9'h1, 9'(irq_req.tx_empty));
        // last data bit low, so a stop bit lost to the back-to-back load would show
        wr(ADDR_DATA, 8'h5A);
        wr(ADDR_DATA, 8'h3C);
        rc(ADDR_STAT_A, "status", 8'h00, 8'hFC);
        chk("irq empty", 9'h0, 9'(irq_req.tx_empty));
        wr(ADDR_CTRL_B, 8'h40);
        chk("oe", 9'h1, 9'(serial_out_oe));
        for (int i = 0; i < 3000 && serial_out_oe; i++)
            @(posedge ref_clk);
        wait_q(2);
        txc(9'h05A, 1'b0);
        txc(9'h03C, 1'b0);
        rc(ADDR_STAT_A, "status", 8'h60, 8'hFC);
        chk("irq done", 9'h1, 9'(irq_req.tx_done));
        chk("oe", 9'h0, 9'(serial_out_oe));
        wr(ADDR_STAT_A, 8'h40);
        rc(ADDR_STAT_A, "status", 8'h20, 8'hFC);
        chk("irq done", 9'h0, 9'(irq_req.tx_done));
        foreach (rows[k])
        begin
            {code, pp, d, sv} = rows[k];
            nb = (code == SIZE_NINE) ? 9 : int'(code) + 5;
            m = d & 9'((1 << nb) - 1);
            utxb_remote_i.cfg(nb, pp[1], pp[0]);
            wr(ADDR_CTRL_C, {2'h0, pp, 1'b0, code[1:0], 1'b0});
            wr(ADDR_CTRL_B, {5'h13, code[2], 1'b0, d[8]});
            wr(ADDR_DATA, d[7:0]);
            wait_q(1);
            txc(m, pp[1] & (^m ^ pp[0]));
            utxb_remote_i.send(d, sv);
            chk("irq rx", 9'h1, 9'(irq_req.rx_done));
            tx_done_irq_ack <= 1'b1;
            @(posedge ref_clk);
            tx_done_irq_ack <= 1'b0;
            rc(ADDR_STAT_A, "status", {3'h5, ~sv, 4'h0}, 8'hFC);
            rd(ADDR_CTRL_B);
            if (code == SIZE_NINE)
                chk("rx ninth", 9'(d[8]), 9'(rv[BIT_RX8]));
            rc(ADDR_DATA, "rx data", m[7:0]);
            rc(ADDR_STAT_A, "status", 8'h20, 8'hFC);
        end
        utxb_remote_i.cfg(8, 1'b0, 1'b0);
        wr(ADDR_CTRL_C, RST_CTRL_C);
        wr(ADDR_CTRL_B, 8'h90);
        utxb_remote_i.send(9'h011, 1'b0);
        utxb_remote_i.send(9'h022, 1'b1);
        chk("owned", 9'h1, 9'(rx_pin_owned));
        global_irq_en <= 1'b0;
        rc(ADDR_STAT_A, "status", 8'hB0, 8'hFC);
        chk("irq rx", 9'h0, 9'(irq_req.rx_done));
        global_irq_en <= 1'b1;
        rc(ADDR_DATA, "rx data", 8'h11);
        rc(ADDR_STAT_A, "status", 8'hA0, 8'hFC);
        rc(ADDR_DATA, "rx data", 8'h22);
        rc(ADDR_DATA, "empty read", 8'h00);
        rc(ADDR_STAT_A, "status", 8'h20, 8'hFC);
        // far end sends odd parity against even, so every entry has a parity error
        wr(ADDR_CTRL_C, 8'h26);
        utxb_remote_i.cfg(8, 1'b1, 1'b1);
        utxb_remote_i.send(9'h044, 1'b1);
        utxb_remote_i.send(9'h055, 1'b1);
        utxb_remote_i.send(9'h066, 1'b1);
        rc(ADDR_STAT_A, "status", 8'hA4, 8'hFC);
        rc(ADDR_DATA, "rx data", 8'h44);
        rc(ADDR_DATA, "rx data", 8'h55);
        // the third frame met a full buffer, so the next stored entry carries overrun
        utxb_remote_i.send(9'h077, 1'b1);
        rc(ADDR_STAT_A, "status", 8'hAC, 8'hFC);
        rc(ADDR_DATA, "rx data", 8'h77);
        utxb_remote_i.cfg(8, 1'b0, 1'b0);
        wr(ADDR_CTRL_C, RST_CTRL_C);
        utxb_remote_i.send(9'h033, 1'b1);
        wr(ADDR_CTRL_B, 8'h00);
        rc(ADDR_STAT_A, "status", 8'h20, 8'hFC);
        chk("owned", 9'h0, 9'(rx_pin_owned));
        sync_mode <= 1'b1;
        wr(ADDR_CTRL_B, 8'h08);
        wr(ADDR_DATA, 8'h96);
        wait_q(1);
        txc(9'h096, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire

//--- testbench/utxb_remote.sv
// remote serial transceiver model that faces the block across the line
`timescale 1ns/1ps
`default_nettype none
module utxb_remote (
    // bit timing
    input  wire logic ref_clk,
    input  wire logic tick,
    // serial line
    input  wire logic line_in,
    output logic      line_out
);
    int          nb = 8;
    logic        pen = 1'b0;
    logic        podd = 1'b0;
    int          cnt = -1;
    logic [10:0] got = '0;
    logic [10:0] rxq[$];

    // the line idles high between frames
    initial line_out = 1'b1;

    task automatic cfg(input int n, input logic p, input logic o);
        nb = n;
        pen = p;
        podd = o;
    endtask

    task automatic bit_out(input logic b);
        do @(posedge ref_clk); while (!tick);
        line_out <= b;
    endtask

    // two idle bits close each frame so the far end has stored it on return
    task automatic send(input logic [8:0] d, input logic stop_v);
        logic [8:0] m;
        m = d & 9'((1 << nb) - 1);
        bit_out(1'b0);
        for (int i = 0; i < nb; i++)
            bit_out(m[i]);
        if (pen)
            bit_out(^m ^ podd);
        bit_out(stop_v);
        bit_out(1'b1);
        bit_out(1'b1);
    endtask

    // entry is {stop, parity, data}; a second stop bit just looks like idle
    always @(posedge ref_clk)
        if (tick)
        begin
            if (cnt < 0)
            begin
                if (!line_in)
                begin
                    cnt = 0;
                    got = '0;
                end
            end
            else
            begin
                if (cnt < nb)
                    got[cnt] = line_in;
                else if (pen && cnt == nb)
                    got[9] = line_in;
                else
                begin
                    got[10] = line_in;
                    rxq.push_back(got);
                end
                cnt = (cnt == nb + int'(pen)) ? -1 : cnt + 1;
            end
        end
endmodule
`default_nettype wire
